// [boe_cfg.svh]
// Constants for the blit operand expansion block.
// Assumes inclusion by bare name from the package, the design file and the checker.
`ifndef BOE_CFG_SVH
`define BOE_CFG_SVH

`define BOE_COL_W 32
`define BOE_QW_BITS 64
`define BOE_FIFO_DEPTH 4
`define BOE_COORD_W 16
`define BOE_ADDR_W 32

// Colour depth codes
`define BOE_DEPTH_8 2'h0
`define BOE_DEPTH_16 2'h1
`define BOE_DEPTH_24 2'h2
`define BOE_DEPTH_32 2'h3

// Colour masks per depth
`define BOE_MASK_8 32'h000000ff
`define BOE_MASK_16 32'h0000ffff
`define BOE_MASK_24 32'h00ffffff
`define BOE_MASK_32 32'hffffffff

// Pattern layout: row stride shift per depth, 24 bpp rows keep the 32-byte stride of 32 bpp
`define BOE_PAT_ROW_SH_8 3'h3
`define BOE_PAT_ROW_SH_16 3'h4
`define BOE_PAT_ROW_SH_24 3'h5
`define BOE_PAT_ROW_SH_32 3'h5
`define BOE_PAT_ADDR_LSB 3

// Mono source line alignment: lines start on 16-bit words except in text mode
`define BOE_WORD_ROUND 7'h0f
`define BOE_WORD_MASK 7'h70

`endif

// [boe_pkg.sv]
// Types shared by the blit operand expansion block.
// Assumes boe_cfg.svh is on the include path.
`default_nettype none
`include "boe_cfg.svh"

package boe_pkg;

    typedef struct packed
    {
        logic src_mono;
        logic pat_mono;
        logic text;
        logic [7:0] rop;
    } boe_cmd_s;

    typedef struct packed
    {
        logic [`BOE_ADDR_W-1:0] addr;
        logic [`BOE_COL_W-1:0] src;
        logic [`BOE_COL_W-1:0] pat;
        logic src_bit;
        logic wr_en;
        logic [1:0] depth;
    } boe_pix_s;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_PAT_REQ,
        ST_PAT_WAIT,
        ST_EMIT
    } boe_state_e;

endpackage : boe_pkg

`default_nettype wire

// [boe_top.sv]
// Operand expansion for a 2D block-transfer engine, with its source FIFO.
// Assumes one clock, synchronous inputs, and geometry inputs held during busy.
`timescale 1ns/10ps
`default_nettype none
`include "boe_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Source quadword FIFO

module boe_fifo
#(
    parameter int unsigned WIDTH = `BOE_QW_BITS,
    parameter int unsigned DEPTH = `BOE_FIFO_DEPTH
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire logic push = i_in_valid && o_in_ready;
    wire logic pop = o_out_valid && i_out_ready;
    wire logic [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    wire logic [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire logic [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_in_ready <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= next_wr_ptr;
            if (pop)
                rd_ptr <= next_rd_ptr;
            count <= next_count;
            o_in_ready <= (next_count != (AW + 1)'(DEPTH));
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

endmodule : boe_fifo

////////////////////////////////////////////////////////////////////////////////
// Operand expansion engine

module boe_top
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_START,
    input wire boe_pkg::boe_cmd_s I_CMD,
    input wire logic [1:0] I_DEPTH,
    input wire logic [`BOE_COL_W-1:0] I_SRC_FG,
    input wire logic [`BOE_COL_W-1:0] I_SRC_BG,
    input wire logic [`BOE_COL_W-1:0] I_PAT_FG,
    input wire logic [`BOE_COL_W-1:0] I_PAT_BG,
    input wire logic [2:0] I_MONO_START,
    input wire logic [`BOE_ADDR_W-1:0] I_PAT_ADDR,
    input wire logic [`BOE_QW_BITS-1:0] I_PAT_MONO,
    input wire logic [2:0] I_PAT_VALIGN,
    input wire logic [`BOE_ADDR_W-1:0] I_DST_ADDR,
    input wire logic [`BOE_COORD_W-1:0] I_DST_PITCH,
    input wire logic [`BOE_COORD_W-1:0] I_DST_WIDTH,
    input wire logic [`BOE_COORD_W-1:0] I_DST_HEIGHT,
    input wire logic [`BOE_COORD_W-1:0] I_DST_X1,
    input wire logic [`BOE_COORD_W-1:0] I_DST_X2,
    input wire logic [`BOE_ADDR_W-1:0] I_DST_Y1_ADDR,
    input wire logic [`BOE_ADDR_W-1:0] I_DST_Y2_ADDR,
    input wire logic [`BOE_COORD_W-1:0] I_CLIP_X1,
    input wire logic [`BOE_COORD_W-1:0] I_CLIP_X2,
    input wire logic [`BOE_ADDR_W-1:0] I_CLIP_Y1_ADDR,
    input wire logic [`BOE_ADDR_W-1:0] I_CLIP_Y2_ADDR,
    input wire logic I_SRC_VALID,
    input wire logic [`BOE_QW_BITS-1:0] I_SRC_DATA,
    output logic O_SRC_READY,
    output logic O_PAT_RD,
    output logic [`BOE_ADDR_W-1:0] O_PAT_ADDR,
    input wire logic I_PAT_RVALID,
    input wire logic [`BOE_COL_W-1:0] I_PAT_RDATA,
    output logic O_PIX_VALID,
    output boe_pkg::boe_pix_s O_PIX,
    input wire logic I_PIX_READY,
    output logic O_BUSY,
    output logic O_DONE
);

    ////////////////////////////////////////////////////////////////////////////
    // Operand dependency on the raster operation

    function automatic logic rop_uses_pat(input logic [7:0] rop);
        rop_uses_pat = (rop[7:4] != rop[3:0]);
    endfunction : rop_uses_pat

    function automatic logic rop_uses_src(input logic [7:0] rop);
        rop_uses_src = ({rop[7:6], rop[3:2]} != {rop[5:4], rop[1:0]});
    endfunction : rop_uses_src

    ////////////////////////////////////////////////////////////////////////////
    // State

    boe_pkg::boe_state_e state;
    boe_pkg::boe_state_e next_state;
    boe_pkg::boe_cmd_s cmd;
    logic [1:0] depth;
    logic [6:0] ptr;
    logic [6:0] next_ptr;
    logic q_ok;
    logic [`BOE_QW_BITS-1:0] q_word;
    logic [`BOE_COORD_W-1:0] xcnt;
    logic [`BOE_COORD_W-1:0] next_xcnt;
    logic [`BOE_COORD_W-1:0] ycnt;
    logic [`BOE_COORD_W-1:0] next_ycnt;
    logic [`BOE_ADDR_W-1:0] line_addr;
    logic [`BOE_ADDR_W-1:0] next_line_addr;
    logic [`BOE_COL_W-1:0] pat_word;
    logic [`BOE_QW_BITS-1:0] pat_mono;

    ////////////////////////////////////////////////////////////////////////////
    // Source FIFO

    wire logic fifo_valid;
    wire logic [`BOE_QW_BITS-1:0] fifo_data;
    wire logic src_used = cmd.src_mono && rop_uses_src(cmd.rop);
    wire logic pat_used = rop_uses_pat(cmd.rop);
    wire logic pat_fetch = pat_used && !cmd.pat_mono;
    wire logic busy_st = (state != boe_pkg::ST_IDLE);
    wire logic q_need = src_used && (!q_ok || ptr[6]);
    // Only an active operation may pull a word, so idle never drops source data
    wire logic q_take = busy_st && q_need;
    wire logic fifo_pop = q_take && fifo_valid;

    boe_fifo
    #(
        .WIDTH(`BOE_QW_BITS),
        .DEPTH(`BOE_FIFO_DEPTH)
    )
    u_src_fifo
    (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_in_valid(I_SRC_VALID),
        .i_in_data(I_SRC_DATA),
        .o_in_ready(O_SRC_READY),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(q_take)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Depth decode

    wire logic [2:0] pix_bytes = {1'b0, depth} + 3'h1;
    wire logic [`BOE_COL_W-1:0] col_mask =
        (depth == `BOE_DEPTH_8) ? `BOE_MASK_8 :
        (depth == `BOE_DEPTH_16) ? `BOE_MASK_16 :
        (depth == `BOE_DEPTH_24) ? `BOE_MASK_24 : `BOE_MASK_32;
    wire logic [2:0] row_sh =
        (depth == `BOE_DEPTH_8) ? `BOE_PAT_ROW_SH_8 :
        (depth == `BOE_DEPTH_16) ? `BOE_PAT_ROW_SH_16 :
        (depth == `BOE_DEPTH_24) ? `BOE_PAT_ROW_SH_24 : `BOE_PAT_ROW_SH_32;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry

    wire logic [`BOE_COORD_W-1:0] x_base = cmd.text ? I_DST_X1 : '0;
    wire logic [`BOE_COORD_W-1:0] xpos = x_base + xcnt;
    wire logic [`BOE_COORD_W-1:0] x_last = cmd.text ? (I_DST_X2 - I_DST_X1)
                                                    : (I_DST_WIDTH - 1'b1);
    wire logic last_x = (xcnt == x_last);
    wire logic last_line = cmd.text ? (line_addr == I_DST_Y2_ADDR)
                                    : (ycnt == I_DST_HEIGHT - 1'b1);
    wire logic [`BOE_ADDR_W-1:0] pix_addr =
        line_addr + `BOE_ADDR_W'(xpos) * `BOE_ADDR_W'(pix_bytes);
    wire logic [`BOE_ADDR_W-1:0] line_step =
        line_addr + `BOE_ADDR_W'(I_DST_PITCH);

    // Text clipping against the clip rectangle
    wire logic clip_x = (xpos >= I_CLIP_X1) && (xpos <= I_CLIP_X2);
    wire logic clip_y = (line_addr >= I_CLIP_Y1_ADDR) && (line_addr <= I_CLIP_Y2_ADDR);
    wire logic wr_ok = !cmd.text || (clip_x && clip_y);

    ////////////////////////////////////////////////////////////////////////////
    // Pattern addressing and selection

    wire logic [2:0] pat_row = ycnt[2:0] + I_PAT_VALIGN;
    wire logic [2:0] pat_col = xpos[2:0];
    wire logic [`BOE_ADDR_W-1:0] pat_base =
        {I_PAT_ADDR[`BOE_ADDR_W-1:`BOE_PAT_ADDR_LSB], `BOE_PAT_ADDR_LSB'(0)};
    wire logic [`BOE_ADDR_W-1:0] pat_row_off = `BOE_ADDR_W'(pat_row) << row_sh;
    // Colour bytes pack at pix_bytes per pixel; the last quadword of a 24 bpp row stays unused
    wire logic [`BOE_ADDR_W-1:0] pat_col_off =
        `BOE_ADDR_W'(pat_col) * `BOE_ADDR_W'(pix_bytes);
    wire logic [`BOE_ADDR_W-1:0] pat_fetch_addr = pat_base + pat_row_off + pat_col_off;
    wire logic pat_bit = pat_mono[{pat_row, ~pat_col}];
    wire logic [`BOE_COL_W-1:0] pat_mono_col = pat_bit ? I_PAT_FG : I_PAT_BG;
    wire logic [`BOE_COL_W-1:0] pat_col_val =
        !pat_used ? '0 : ((cmd.pat_mono ? pat_mono_col : pat_word) & col_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Source bit selection and line alignment

    wire logic have_bit = !src_used || (q_ok && !ptr[6]);
    wire logic src_bit = src_used && q_word[{ptr[5:3], ~ptr[2:0]}];
    wire logic [`BOE_COL_W-1:0] src_col_val =
        !src_used ? '0 : ((src_bit ? I_SRC_FG : I_SRC_BG) & col_mask);
    wire logic [6:0] ptr_inc = ptr + 7'h1;
    wire logic [6:0] ptr_word = (ptr_inc + `BOE_WORD_ROUND) & `BOE_WORD_MASK;
    wire logic [6:0] ptr_line = cmd.text ? ptr_inc
                                         : ptr_word + {4'h0, I_MONO_START};
    wire logic [6:0] ptr_loaded = q_ok ? {1'b0, ptr[5:0]} : ptr;

    wire logic slot_free = !O_PIX_VALID || I_PIX_READY;
    wire logic emit = (state == boe_pkg::ST_EMIT) && have_bit && slot_free;
    wire logic op_end = emit && last_x && last_line;
    wire logic start_ok = (state == boe_pkg::ST_IDLE) && I_START;
    wire logic start_fetch = rop_uses_pat(I_CMD.rop) && !I_CMD.pat_mono;

    boe_pkg::boe_pix_s next_pix;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        next_state = state;
        next_ptr = fifo_pop ? ptr_loaded : ptr;
        next_xcnt = xcnt;
        next_ycnt = ycnt;
        next_line_addr = line_addr;
        next_pix.addr = pix_addr;
        next_pix.src = src_col_val;
        next_pix.pat = pat_col_val;
        next_pix.src_bit = src_bit;
        next_pix.wr_en = wr_ok;
        next_pix.depth = depth;
        case (state)
            boe_pkg::ST_IDLE:
            begin
                if (I_START)
                begin
                    next_ptr = {4'h0, I_MONO_START};
                    next_xcnt = '0;
                    next_ycnt = '0;
                    next_line_addr = I_CMD.text ? I_DST_Y1_ADDR : I_DST_ADDR;
                    next_state = start_fetch ? boe_pkg::ST_PAT_REQ : boe_pkg::ST_EMIT;
                end
            end
            boe_pkg::ST_PAT_REQ:
            begin
                next_state = boe_pkg::ST_PAT_WAIT;
            end
            boe_pkg::ST_PAT_WAIT:
            begin
                if (I_PAT_RVALID)
                    next_state = boe_pkg::ST_EMIT;
            end
            boe_pkg::ST_EMIT:
            begin
                if (emit)
                begin
                    if (last_x)
                    begin
                        next_xcnt = '0;
                        next_ycnt = ycnt + 1'b1;
                        next_line_addr = line_step;
                        next_ptr = ptr_line;
                    end
                    else
                    begin
                        next_xcnt = xcnt + 1'b1;
                        next_ptr = ptr_inc;
                    end
                    if (op_end)
                        next_state = boe_pkg::ST_IDLE;
                    else if (pat_fetch)
                        next_state = boe_pkg::ST_PAT_REQ;
                end
            end
            default:
            begin
                next_state = boe_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            state <= boe_pkg::ST_IDLE;
            ptr <= '0;
            xcnt <= '0;
            ycnt <= '0;
            line_addr <= '0;
        end
        else
        begin
            state <= next_state;
            ptr <= next_ptr;
            xcnt <= next_xcnt;
            ycnt <= next_ycnt;
            line_addr <= next_line_addr;
        end
    end

    // Command, depth and mono pattern captured at start
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            cmd <= '0;
            depth <= `BOE_DEPTH_8;
            pat_mono <= '0;
        end
        else if (start_ok)
        begin
            cmd <= I_CMD;
            depth <= I_DEPTH;
            pat_mono <= I_PAT_MONO;
        end
    end

    // Current source quadword
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            q_ok <= 1'b0;
            q_word <= '0;
        end
        else if (start_ok)
            q_ok <= 1'b0;
        else if (fifo_pop)
        begin
            q_ok <= 1'b1;
            q_word <= fifo_data;
        end
    end

    // Colour pattern fetch from memory
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_PAT_RD <= 1'b0;
            O_PAT_ADDR <= '0;
            pat_word <= '0;
        end
        else
        begin
            O_PAT_RD <= (state == boe_pkg::ST_PAT_REQ);
            if (state == boe_pkg::ST_PAT_REQ)
                O_PAT_ADDR <= pat_fetch_addr;
            if ((state == boe_pkg::ST_PAT_WAIT) && I_PAT_RVALID)
                pat_word <= I_PAT_RDATA;
        end
    end

    // Pixel output stage and status
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_PIX_VALID <= 1'b0;
            O_PIX <= '0;
            O_BUSY <= 1'b0;
            O_DONE <= 1'b0;
        end
        else
        begin
            if (emit)
            begin
                O_PIX_VALID <= 1'b1;
                O_PIX <= next_pix;
            end
            else if (I_PIX_READY)
                O_PIX_VALID <= 1'b0;
            O_BUSY <= (next_state != boe_pkg::ST_IDLE);
            O_DONE <= op_end;
        end
    end

endmodule : boe_top

`default_nettype wire

// [boe_checker.sv]
// Port assertions for boe_top.
// Assumes boe_pkg compiled first and boe_cfg.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "boe_cfg.svh"

module boe_checker
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_START,
    input wire logic [1:0] I_DEPTH,
    input wire logic [`BOE_COL_W-1:0] I_SRC_FG,
    input wire logic [`BOE_COL_W-1:0] I_SRC_BG,
    input wire logic [`BOE_ADDR_W-1:0] I_PAT_ADDR,
    input wire logic O_PAT_RD,
    input wire logic [`BOE_ADDR_W-1:0] O_PAT_ADDR,
    input wire logic I_PIX_READY,
    input wire logic O_PIX_VALID,
    input wire boe_pkg::boe_pix_s O_PIX,
    input wire logic O_BUSY,
    input wire logic O_DONE
);
logic [1:0] depth;
logic [31:0] mask;
logic [31:0] pat_off;
assign mask = (depth == `BOE_DEPTH_8) ? `BOE_MASK_8 : (depth == `BOE_DEPTH_16) ? `BOE_MASK_16 :
              (depth == `BOE_DEPTH_24) ? `BOE_MASK_24 : `BOE_MASK_32;
assign pat_off = O_PAT_ADDR - {I_PAT_ADDR[31:3], 3'h0};

// Depth in force for the running operation
always_ff @(posedge I_CLK or negedge I_NRST)
    if (!I_NRST)
        depth <= 2'h0;
    else if (I_START && !O_BUSY)
        depth <= I_DEPTH;

default clocking cb @(posedge I_CLK); endclocking
default disable iff (!I_NRST);

sequence s_stall;
    O_PIX_VALID && !I_PIX_READY;
endsequence
sequence s_take;
    I_START && !O_BUSY;
endsequence
// A pixel freshly loaded at the last edge, not one held over through a stall
sequence s_new;
    O_PIX_VALID && (!$past(O_PIX_VALID) || $past(I_PIX_READY));
endsequence

pat_rd_pulse_a: assert property (O_PAT_RD |=> !O_PAT_RD)
    else $error("pattern read longer than one cycle");
pat_window_a: assert property (O_PAT_RD |-> pat_off < 32'h100)
    else $error("pattern address outside its block");
pix_hold_a: assert property (s_stall |=> O_PIX_VALID && $stable(O_PIX))
    else $error("pixel changed while stalled");
done_pulse_a: assert property (O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
done_end_a: assert property (O_DONE |-> !O_BUSY && O_PIX_VALID)
    else $error("done without last pixel");
busy_fall_a: assert property ($fell(O_BUSY) |-> O_DONE)
    else $error("busy fell without done");
start_busy_a: assert property (s_take |=> O_BUSY)
    else $error("start not taken");
pix_depth_a: assert property (s_new |-> O_PIX.depth == depth)
    else $error("pixel depth differs from operation");
mask_limit_a: assert property (s_new |-> ((O_PIX.src | O_PIX.pat) & ~mask) == 0)
    else $error("colour wider than depth");
src_expand_a: assert property (s_new |-> O_PIX.src == 0 ||
    O_PIX.src == ((O_PIX.src_bit ? $past(I_SRC_FG) : $past(I_SRC_BG)) & mask))
    else $error("source colour not from expansion registers");

endmodule : boe_checker

bind boe_top boe_checker i_chk (.I_CLK, .I_NRST, .I_START, .I_DEPTH, .I_SRC_FG, .I_SRC_BG,
    .I_PAT_ADDR, .O_PAT_RD, .O_PAT_ADDR, .I_PIX_READY, .O_PIX_VALID, .O_PIX, .O_BUSY, .O_DONE);
`default_nettype wire

// [boe_mem_model.sv]
// Graphics memory model answering colour pattern reads.
// Assumes one read outstanding; address stands until the next request.
`timescale 1ns/10ps
`default_nettype none

module boe_mem_model
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_rd,
    input wire logic [31:0] i_addr,
    output logic o_rvalid,
    output logic [31:0] o_rdata
);
logic pend;
logic slow;
logic [1:0] cnt;

// Answers alternate prompt and slow; data churns outside an answer
always @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
        {pend, slow, cnt, o_rvalid} <= '0;
        o_rdata <= '0;
    end
    else
    begin
        o_rvalid <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_rd)
        begin
            pend <= 1'b1;
            cnt <= slow ? 2'h2 : 2'h0;
            slow <= ~slow;
        end
        else if (pend && cnt != 2'h0)
            cnt <= cnt - 2'h1;
        else if (pend)
        begin
            pend <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {i_addr[15:0], ~i_addr[15:0]};
        end
    end

endmodule : boe_mem_model
`default_nettype wire

// [boe_top_tb.sv]
// Self-checking bench for boe_top with a memory model on the pattern port.
// Assumes boe_pkg, boe_top, boe_checker and boe_mem_model compiled first.
`timescale 1ns/10ps
`default_nettype none

module boe_top_tb;
localparam logic [31:0] FG = 32'h11223344, BG = 32'h55667788;
localparam logic [31:0] PFG = 32'h99aabbcc, PBG = 32'hddeeff01;
logic clk = 0, nrst = 0, start = 0, sv = 0, prdy = 0, prd, prv, pv, busy, done, sr;
boe_pkg::boe_cmd_s cmd = '0;
boe_pkg::boe_pix_s pix;
boe_pkg::boe_pix_s got[$];
logic [1:0] dep = 0;
logic [2:0] ms = 0, va = 0;
logic [31:0] paddr = 0, dadr = 0, y1 = 0, y2 = 0, cy1 = 0, cy2 = 0, pra, prdat;
logic [15:0] pitch = 16'h0100, w = 1, h = 1, x1 = 0, x2 = 0, cx1 = 0, cx2 = 0;
logic [63:0] pm = 0, sd = 0;
logic [63:0] wd[4];
int error_cnt = 0, cmp_count = 0, nrd = 0, cyc = 0;

boe_top i_dut (.I_CLK(clk), .I_NRST(nrst), .I_START(start), .I_CMD(cmd), .I_DEPTH(dep),
    .I_SRC_FG(FG), .I_SRC_BG(BG), .I_PAT_FG(PFG), .I_PAT_BG(PBG), .I_MONO_START(ms),
    .I_PAT_ADDR(paddr), .I_PAT_MONO(pm), .I_PAT_VALIGN(va), .I_DST_ADDR(dadr),
    .I_DST_PITCH(pitch), .I_DST_WIDTH(w), .I_DST_HEIGHT(h), .I_DST_X1(x1), .I_DST_X2(x2),
    .I_DST_Y1_ADDR(y1), .I_DST_Y2_ADDR(y2), .I_CLIP_X1(cx1), .I_CLIP_X2(cx2),
    .I_CLIP_Y1_ADDR(cy1), .I_CLIP_Y2_ADDR(cy2), .I_SRC_VALID(sv), .I_SRC_DATA(sd),
    .O_SRC_READY(sr), .O_PAT_RD(prd), .O_PAT_ADDR(pra), .I_PAT_RVALID(prv),
    .I_PAT_RDATA(prdat), .O_PIX_VALID(pv), .O_PIX(pix), .I_PIX_READY(prdy),
    .O_BUSY(busy), .O_DONE(done));
boe_mem_model i_mem (.i_clk(clk), .i_nrst(nrst), .i_rd(prd), .i_addr(pra),
    .o_rvalid(prv), .o_rdata(prdat));

always #20 clk = ~clk;

// Stalling sink, pixel collector and fetch counter
always @(posedge clk)
begin
    cyc <= cyc + 1;
    prdy <= (cyc % 3) != 0;
    if (pv === 1'b1 && prdy === 1'b1)
        got.push_back(pix);
    if (prd === 1'b1)
        nrd++;
end

////////////////////////////////////////////////////////////////////////////////

function automatic logic bitat(logic [63:0] q, int n);
    return q[(n / 8) * 8 + 7 - n % 8];
endfunction : bitat

function automatic logic [31:0] mk(int d);
    return (d == 3) ? 32'hffffffff : (32'h1 << (8 * (d + 1))) - 32'h1;
endfunction : mk

task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask : tally_and_finish

task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
        error_cnt++;
        $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
endtask : cmp

task automatic pix_cmp(int i, logic [31:0] a, logic [31:0] s, logic [31:0] p, logic wr);
    if (i >= got.size())
        cmp(32'h0, 32'h1, "pixel missing");
    else
    begin
        cmp(got[i].addr, a, "pixel address");
        cmp(got[i].src, s, "source colour");
        cmp(got[i].pat, p, "pattern colour");
        cmp({31'h0, got[i].wr_en}, {31'h0, wr}, "write enable");
        cmp({30'h0, got[i].depth}, {30'h0, dep}, "pixel depth");
    end
endtask : pix_cmp

task automatic push(logic [63:0] q);
    int n;
    @(posedge clk);
    sv <= 1'b1;
    sd <= q;
    n = 0;
    do
    begin
        @(posedge clk);
        n++;
    end
    while (sr !== 1'b1 && n < 100);
    sv <= 1'b0;
    sd <= ~q;
    if (n >= 100)
    begin
        cmp(32'h0, 32'h1, "source wait timeout");
        tally_and_finish();
    end
endtask : push

task automatic run;
    int n;
    got.delete();
    nrd = 0;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do
    begin
        @(posedge clk);
        #1;
        n++;
    end
    while ((busy !== 1'b0 || pv !== 1'b0) && n < 3000);
    if (n >= 3000)
    begin
        cmp(32'h0, 32'h1, "operation timeout");
        tally_and_finish();
    end
    @(posedge clk);
endtask : run

////////////////////////////////////////////////////////////////////////////////

initial
begin
    int n;
    logic [31:0] a;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    // Fill the source buffer until it refuses, then drain it over four depths
    for (int k = 0; k < 4; k++)
    begin
        wd[k] = 64'h0f3ca596e1874b2d + k * 64'h1111111111111111;
        push(wd[k]);
    end
    @(posedge clk);
    #1 cmp({31'h0, sr}, 32'h0, "buffer full");
    @(posedge clk);
    for (int d = 0; d < 4; d++)
    begin
        cmd <= '{src_mono: 1'b1, pat_mono: 1'b0, text: 1'b0, rop: 8'hcc};
        dep <= d[1:0];
        ms <= 3'(d + 1);
        w <= 16'h8;
        h <= 16'h2;
        dadr <= 32'h2000;
        run();
        cmp(nrd, 0, "pattern read without pattern");
        for (int i = 0; i < 16; i++)
        begin
            n = (i / 8) * 16 + d + 1 + i % 8;
            pix_cmp(i, 32'h2000 + (i / 8) * 32'h100 + (i % 8) * (d + 1),
                (bitat(wd[d], n) ? FG : BG) & mk(d), 32'h0, 1'b1);
        end
    end
    #1 cmp({31'h0, sr}, 32'h1, "buffer drained");
    $display("test mono source done");
    // Text glyph with clipping on both axes
    push(wd[1]);
    cmd <= '{src_mono: 1'b1, pat_mono: 1'b0, text: 1'b1, rop: 8'hcc};
    {dep, ms, x1, x2, y1, y2} <= {2'h0, 3'h3, 16'h2, 16'h5, 32'h1000, 32'h1200};
    {cx1, cx2, cy1, cy2} <= {16'h3, 16'h9, 32'h1100, 32'h2000};
    run();
    for (int i = 0; i < 12; i++)
        pix_cmp(i, 32'h1000 + (i / 4) * 32'h100 + 2 + i % 4,
            (bitat(wd[1], 3 + i) ? FG : BG) & mk(0), 32'h0, (i % 4 >= 1) && (i >= 4));
    $display("test text glyph done");
    // Mono pattern copy, no source offered
    cmd <= '{src_mono: 1'b0, pat_mono: 1'b1, text: 1'b0, rop: 8'hf0};
    {dep, va, pm} <= {2'h1, 3'h3, 64'h81422418f00fa55a};
    run();
    cmp(nrd, 0, "mono pattern fetched");
    for (int i = 0; i < 16; i++)
        pix_cmp(i, 32'h2000 + (i / 8) * 32'h100 + (i % 8) * 2, 32'h0,
            (pm[8 * ((i / 8 + 3) % 8) + 7 - i % 8] ? PFG : PBG) & mk(1), 1'b1);
    $display("test mono pattern done");
    // Colour pattern from memory at every depth, low address bits set
    cmd <= '{src_mono: 1'b0, pat_mono: 1'b0, text: 1'b0, rop: 8'hf0};
    {paddr, va, w} <= {32'h00100007, 3'h1, 16'h3};
    for (int d = 0; d < 4; d++)
    begin
        dep <= d[1:0];
        run();
        cmp(nrd, 6, "pattern fetch count");
        for (int i = 0; i < 6; i++)
        begin
            a = 32'h00100000 + (((i / 3 + 1) % 8) << ((d < 2) ? 3 + d : 5)) + (i % 3) * (d + 1);
            pix_cmp(i, 32'h2000 + (i / 3) * 32'h100 + (i % 3) * (d + 1), 32'h0,
                {a[15:0], ~a[15:0]} & mk(d), 1'b1);
        end
    end
    $display("test colour pattern done");
    tally_and_finish();
end

endmodule : boe_top_tb
`default_nettype wire
